// ===== verilog/ble_select.sv
// Summary of operation
// - The LED select goes low only for writes in the $004000 to $01FFFF range with address bit 14 high.
// - LEDs are active low, so data 0 lights all eight and $FF turns all off; data passes unaltered.
// - An LED select pin held low through power-up reset stays tri-stated until a later reset sees it high.
// - A low LED strap at power-up reset disables all LED support logic.
// - With LED support off, writes to boot ROM space still get the word acknowledge if ROM support is on.
// - The EEPROM output enable goes low for reads in the window starting at $408000.
// - EEPROM reads are always served, with no write-enable check, unless the EEPROM strap disabled them.
// - An EEPROM output enable pin held low through power-up reset stays tri-stated until a later reset.
// - A low EEPROM strap at power-up reset disables all EEPROM support logic.
// - The EEPROM write strobe pulses only for writes to the odd byte within the EEPROM window.
// - The EEPROM write strobe is gated by an EEPROM write-enable flag.
// - EEPROM window writes while writes are disabled drop the strobe but still get the acknowledge.
// - With EEPROM support strapped off, EEPROM window writes get no acknowledge.
// - The ROM select goes low for reads from $000000 through the ROM range unless its strap disabled it.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ble_select
  import ble_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire ble_bus_req_s bus_i,
  output var logic word_transfer_ack_n_o,
  input wire logic rom_sel_i,
  output var logic rom_sel_n_o,
  output logic rom_sel_oe_o,
  input wire logic led_sel_i,
  output var logic led_sel_n_o,
  output logic led_sel_oe_o,
  input wire logic eeprom_oe_i,
  output var logic eeprom_oe_n_o,
  output logic eeprom_oe_oe_o,
  output var logic eeprom_we_n_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic apb_mapped(input logic [APB_AW-1:0] a);
    apb_mapped = (a == CTRL_OFS) || (a == STATUS_OFS);
  endfunction : apb_mapped

  ble_state_e state, next_state;
  ble_bus_req_s req, next_req;
  ble_pins_s pins, next_pins;
  logic rom_dis, led_dis, ee_dis;
  logic next_rom_dis, next_led_dis, next_ee_dis;
  logic ee_wr_en, ext_rom, next_ee_wr_en, next_ext_rom;
  logic [31:0] rdata, next_rdata;
  logic strap_done;
  logic apb_setup, apb_wr_ctrl;

  // decode of the live request
  logic live_rom, live_led, live_ee, live_hit;
  logic [23:0] rom_top;

  always_comb begin
    rom_top = ext_rom ? ROM_HI_EXT : ROM_HI;
    live_rom = !rom_dis && in_range(bus_i.addr, ROM_LO, rom_top);
    live_led = !led_dis && bus_i.write && bus_i.addr[LED_ADDR_BIT]
               && in_range(bus_i.addr, LED_LO, LED_HI);
    live_ee = !ee_dis && in_range(bus_i.addr, EE_LO, EE_HI);
    live_hit = live_rom || live_led || live_ee;
  end

  // decode of the held request
  logic req_rom, req_led, req_ee;

  always_comb begin
    req_rom = !rom_dis && in_range(req.addr, ROM_LO, rom_top);
    req_led = !led_dis && req.write && req.addr[LED_ADDR_BIT]
              && in_range(req.addr, LED_LO, LED_HI);
    req_ee = !ee_dis && in_range(req.addr, EE_LO, EE_HI);
  end

  assign strap_done = (state != ST_STRAP);

  function automatic logic req_led_next(input ble_bus_req_s r);
    req_led_next = !led_dis && r.write && r.addr[LED_ADDR_BIT]
                   && in_range(r.addr, LED_LO, LED_HI);
  endfunction : req_led_next

  // bus cycle sequencer and pin drive
  always_comb begin
    next_state = state;
    next_req = req;
    next_pins = PINS_IDLE;
    case (state)
      ST_STRAP: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (bus_i.cycle && live_hit) begin
          next_state = ST_SEL;
          next_req = bus_i;
        end
      end
      ST_SEL: begin
        next_state = bus_i.cycle ? ST_ACK : ST_IDLE;
      end
      ST_ACK: begin
        if (!bus_i.cycle) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (next_state == ST_SEL || next_state == ST_ACK) begin
      // data passes straight to the led latch, so 0 lights all, FF clears all
      next_pins.led_n = !req_led_next(next_req);
      next_pins.rom_n = !(!rom_dis && !next_req.write
                          && in_range(next_req.addr, ROM_LO, rom_top));
      next_pins.ee_oe_n = !(!ee_dis && !next_req.write
                            && in_range(next_req.addr, EE_LO, EE_HI));
      next_pins.ee_we_n = !(!ee_dis && ee_wr_en && next_req.write && !next_req.lower_ds_n
                            && in_range(next_req.addr, EE_LO, EE_HI));
    end
    if (next_state == ST_ACK) begin
      next_pins.ack_n = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_STRAP;
      req <= REQ_RESET;
      pins <= PINS_IDLE;
    end else begin
      state <= next_state;
      req <= next_req;
      pins <= next_pins;
    end
  end

  // straps: pins float during reset, sampled on the first edge after release
  always_comb begin
    next_rom_dis = rom_dis;
    next_led_dis = led_dis;
    next_ee_dis = ee_dis;
    if (state == ST_STRAP) begin
      next_rom_dis = !rom_sel_i;
      next_led_dis = !led_sel_i;
      next_ee_dis = !eeprom_oe_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rom_dis <= 1'b0;
      led_dis <= 1'b0;
      ee_dis <= 1'b0;
    end else begin
      rom_dis <= next_rom_dis;
      led_dis <= next_led_dis;
      ee_dis <= next_ee_dis;
    end
  end

  assign rom_sel_oe_o = strap_done && !rom_dis;
  assign led_sel_oe_o = strap_done && !led_dis;
  assign eeprom_oe_oe_o = strap_done && !ee_dis;
  assign rom_sel_n_o = pins.rom_n;
  assign led_sel_n_o = pins.led_n;
  assign eeprom_oe_n_o = pins.ee_oe_n;
  assign eeprom_we_n_o = pins.ee_we_n;
  assign word_transfer_ack_n_o = pins.ack_n;

  // apb slave, zero wait states
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr_ctrl = psel_i && penable_i && pwrite_i && (paddr_i == CTRL_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !apb_mapped(paddr_i);
  assign prdata_o = rdata;

  always_comb begin
    next_ee_wr_en = ee_wr_en;
    next_ext_rom = ext_rom;
    next_rdata = rdata;
    if (apb_wr_ctrl) begin
      next_ee_wr_en = pwdata_i[CTRL_EE_WR_EN];
      next_ext_rom = pwdata_i[CTRL_EXT_ROM];
    end
    if (apb_setup && !pwrite_i) begin
      next_rdata = 32'h00000000;
      if (paddr_i == CTRL_OFS) begin
        next_rdata[CTRL_EE_WR_EN] = ee_wr_en;
        next_rdata[CTRL_EXT_ROM] = ext_rom;
      end else if (paddr_i == STATUS_OFS) begin
        next_rdata[STAT_ROM_DIS] = rom_dis;
        next_rdata[STAT_LED_DIS] = led_dis;
        next_rdata[STAT_EE_DIS] = ee_dis;
        next_rdata[STAT_STRAP_DONE] = strap_done;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ee_wr_en <= CTRL_RESET[CTRL_EE_WR_EN];
      ext_rom <= CTRL_RESET[CTRL_EXT_ROM];
      rdata <= 32'h00000000;
    end else begin
      ee_wr_en <= next_ee_wr_en;
      ext_rom <= next_ext_rom;
      rdata <= next_rdata;
    end
  end

  AST_LED_DECODE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !led_sel_n_o |-> req.write && req.addr[LED_ADDR_BIT] && in_range(req.addr, LED_LO, LED_HI))
    else $error("led select outside led write window");

  AST_LED_FLOAT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    led_dis |-> !led_sel_oe_o)
    else $error("led select driven while strapped off");

  AST_LED_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    led_dis |-> led_sel_n_o)
    else $error("led select active while strapped off");

  AST_ROM_WRITE_ACK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_SEL && bus_i.cycle && req.write && req_rom) |=> !word_transfer_ack_n_o)
    else $error("rom space write not acknowledged");

  AST_EE_READ: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !eeprom_oe_n_o |-> !req.write && in_range(req.addr, EE_LO, EE_HI))
    else $error("eeprom output enable outside read window");

  AST_EE_READ_SERVED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_IDLE && bus_i.cycle && !bus_i.write && live_ee) |=> !eeprom_oe_n_o [*1] ##0
    (state == ST_SEL))
    else $error("eeprom read not served");

  AST_EE_FLOAT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ee_dis |-> !eeprom_oe_oe_o && eeprom_oe_n_o)
    else $error("eeprom enable driven while strapped off");

  AST_EE_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    ee_dis |-> eeprom_we_n_o)
    else $error("eeprom strobe active while strapped off");

  AST_EE_STROBE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !eeprom_we_n_o |-> req.write && !req.lower_ds_n && in_range(req.addr, EE_LO, EE_HI))
    else $error("eeprom strobe outside odd byte write window");

  AST_EE_GATED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !eeprom_we_n_o |-> ee_wr_en)
    else $error("eeprom strobe without write enable");

  AST_EE_LOCKED_ACK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_SEL && bus_i.cycle && req.write && req_ee && !ee_wr_en)
    |=> !word_transfer_ack_n_o && eeprom_we_n_o)
    else $error("locked eeprom write not acknowledged");

  AST_EE_NO_ACK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (ee_dis && state == ST_IDLE && bus_i.cycle && in_range(bus_i.addr, EE_LO, EE_HI))
    |=> state == ST_IDLE && word_transfer_ack_n_o)
    else $error("eeprom write acknowledged while strapped off");

  AST_ROM_SEL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !rom_sel_n_o |-> !rom_dis && !req.write && in_range(req.addr, ROM_LO, rom_top))
    else $error("rom select outside rom read window");

  AST_WR_EN_SRC: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $changed(ee_wr_en) |-> $past(apb_wr_ctrl))
    else $error("write enable changed without control write");

  AST_STRAP_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (strap_done && $past(strap_done)) |-> $stable(led_dis) && $stable(ee_dis) && $stable(rom_dis))
    else $error("strap flag changed after capture");

  AST_LED_STRAP_OE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $rose(strap_done) |-> led_sel_oe_o == $past(led_sel_i))
    else $error("led select drive does not follow its strap");

  AST_EE_STRAP_OE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $rose(strap_done) |-> eeprom_oe_oe_o == $past(eeprom_oe_i))
    else $error("eeprom enable drive does not follow its strap");

  AST_ROM_STRAP_OE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $rose(strap_done) |-> rom_sel_oe_o == $past(rom_sel_i))
    else $error("rom select drive does not follow its strap");

  AST_ROM_OFF: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rom_dis |-> rom_sel_n_o && !rom_sel_oe_o)
    else $error("rom select active while strapped off");

  AST_LED_HELD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !led_sel_n_o |-> req_led)
    else $error("led select without an enabled led write");

  AST_LED_TAKEN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_IDLE && bus_i.cycle && live_led) |=> !led_sel_n_o)
    else $error("led write not selected");

  AST_ROM_TAKEN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_IDLE && bus_i.cycle && !bus_i.write && live_rom) |=> !rom_sel_n_o)
    else $error("rom read not selected");

  AST_EE_WE_TAKEN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_IDLE && bus_i.cycle && bus_i.write && !bus_i.lower_ds_n && live_ee
     && ee_wr_en) |=> !eeprom_we_n_o)
    else $error("enabled odd byte eeprom write not strobed");

  AST_ACK_STANDS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!word_transfer_ack_n_o && bus_i.cycle) |=> !word_transfer_ack_n_o)
    else $error("acknowledge dropped while cycle held");

  AST_CYCLE_END: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !bus_i.cycle |=> word_transfer_ack_n_o && rom_sel_n_o && led_sel_n_o
    && eeprom_oe_n_o && eeprom_we_n_o)
    else $error("outputs not released after cycle end");

  AST_ACK_ORDER: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $fell(word_transfer_ack_n_o) |-> $past(state) == ST_SEL)
    else $error("acknowledge without select phase");

  AST_SEL_ONEHOT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $onehot0({!rom_sel_n_o, !led_sel_n_o, !eeprom_oe_n_o}))
    else $error("more than one select active");

  AST_WE_NOT_OE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !eeprom_we_n_o |-> eeprom_oe_n_o)
    else $error("eeprom strobe and output enable together");

  AST_WR_EN_CLEAR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state == ST_STRAP) |-> !ee_wr_en)
    else $error("write enable set after power-up reset");

  AST_LED_OFF_ACK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (led_dis && !rom_dis && state == ST_SEL && bus_i.cycle && req.write
     && in_range(req.addr, LED_LO, LED_HI)) |=> !word_transfer_ack_n_o && led_sel_n_o)
    else $error("led window write not acknowledged while led strapped off");

endmodule : ble_select
`default_nettype wire

// ===== shared/ble_pkg.sv
package ble_pkg;
  localparam int BUS_AW = 24;
  localparam int APB_AW = 12;
  // backplane address windows
  localparam logic [23:0] ROM_LO = 24'h000000;
  localparam logic [23:0] ROM_HI = 24'h01FFFF;
  localparam logic [23:0] ROM_HI_EXT = 24'h03FFFF;
  localparam logic [23:0] LED_LO = 24'h004000;
  localparam logic [23:0] LED_HI = 24'h01FFFF;
  localparam int LED_ADDR_BIT = 14;
  localparam logic [23:0] EE_LO = 24'h408000;
  localparam logic [23:0] EE_HI = 24'h40FFFF;
  // register offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  // control fields
  localparam int CTRL_EE_WR_EN = 0;
  localparam int CTRL_EXT_ROM = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status fields
  localparam int STAT_ROM_DIS = 0;
  localparam int STAT_LED_DIS = 1;
  localparam int STAT_EE_DIS = 2;
  localparam int STAT_STRAP_DONE = 3;

  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_SEL = 4'b0100,
    ST_ACK = 4'b1000
  } ble_state_e;

  typedef struct packed {
    logic cycle;
    logic write;
    logic upper_ds_n;
    logic lower_ds_n;
    logic [BUS_AW-1:0] addr;
  } ble_bus_req_s;

  localparam ble_bus_req_s REQ_RESET = '{1'b0, 1'b0, 1'b1, 1'b1, 24'h000000};

  typedef struct packed {
    logic rom_n;
    logic led_n;
    logic ee_oe_n;
    logic ee_we_n;
    logic ack_n;
  } ble_pins_s;

  localparam ble_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : ble_pkg

// ===== tb/ble_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ble_pin_model (
  input wire logic [2:0] pull_i,
  input wire logic [2:0] oe_i,
  input wire logic [2:0] drv_n_i,
  output logic [2:0] pin_o
);
  // released pin shows its strap resistor level
  assign pin_o = (oe_i & drv_n_i) | (~oe_i & pull_i);
endmodule : ble_pin_model
`default_nettype wire

// ===== tb/boot_led_eeprom_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module boot_led_eeprom_select_bench import ble_pkg::*;;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ack_n, we_n;
  ble_bus_req_s bus = REQ_RESET;
  logic [2:0] pull = 3'h7, oe, drv_n, pin;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic err;
  int error_cnt = 0, tests_run = 0;
  ble_select uut (.core_clk_i(clk), .reset_n_i(rst_n), .bus_i(bus),
    .word_transfer_ack_n_o(ack_n), .rom_sel_i(pin[2]), .rom_sel_n_o(drv_n[2]),
    .rom_sel_oe_o(oe[2]), .led_sel_i(pin[1]), .led_sel_n_o(drv_n[1]), .led_sel_oe_o(oe[1]),
    .eeprom_oe_i(pin[0]), .eeprom_oe_n_o(drv_n[0]), .eeprom_oe_oe_o(oe[0]),
    .eeprom_we_n_o(we_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  ble_pin_model pins (.pull_i(pull), .oe_i(oe), .drv_n_i(drv_n), .pin_o(pin));
  initial begin
    forever #20 clk = ~clk;
  end
  task end_sim();
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task do_reset(input logic [2:0] p);
    @(posedge clk);
    rst_n <= 1'b0;
    pull <= p;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // e = {rom, led, ee_oe, ee_we, ack}
  task bus_cyc(input logic [23:0] a, input logic wr, input logic [1:0] ds, input logic [4:0] e);
    @(posedge clk);
    bus <= '{1'b1, wr, ds[1], ds[0], a};
    repeat (3) @(posedge clk);
    #1;
    `CHK("pins", e, {drv_n, we_n, ack_n})
    @(posedge clk);
    bus <= REQ_RESET;
    repeat (2) @(posedge clk);
    #1;
    `CHK("idle", 5'h1F, {drv_n, we_n, ack_n})
  endtask : bus_cyc
  task t_rom_led();
    do_reset(3'h7);
    `CHK("oe", 3'h7, oe)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", 32'h8, rd)
    bus_cyc(24'h01FFFF, 1'b1, 2'h0, 5'h16);
    bus_cyc(24'h004000, 1'b1, 2'h0, 5'h16);
    bus_cyc(24'h008000, 1'b1, 2'h0, 5'h1E);
    bus_cyc(24'h01FFFF, 1'b0, 2'h0, 5'h0E);
    bus_cyc(24'h020000, 1'b0, 2'h0, 5'h1F);
    apb(1'b1, CTRL_OFS, 32'h2);
    bus_cyc(24'h03FFFF, 1'b0, 2'h0, 5'h0E);
    bus_cyc(24'h040000, 1'b0, 2'h0, 5'h1F);
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask : t_rom_led
  task t_eeprom();
    bus_cyc(24'h408000, 1'b0, 2'h0, 5'h1A);
    bus_cyc(24'h408001, 1'b1, 2'h2, 5'h1E);
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    bus_cyc(24'h40FFFF, 1'b1, 2'h2, 5'h1C);
    bus_cyc(24'h408000, 1'b1, 2'h1, 5'h1E);
    bus_cyc(24'h40FFFF, 1'b0, 2'h0, 5'h1A);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask : t_eeprom
  task t_strap();
    do_reset(3'h4);
    `CHK("oe", 3'h4, oe)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", 32'hE, rd)
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    bus_cyc(24'h01FFFF, 1'b1, 2'h0, 5'h1E);
    bus_cyc(24'h408000, 1'b0, 2'h0, 5'h1F);
    bus_cyc(24'h408001, 1'b1, 2'h2, 5'h1F);
    do_reset(3'h7);
    `CHK("oe", 3'h7, oe)
  endtask : t_strap
  initial begin
    #(40 * 5000);
    error_cnt++;
    end_sim();
  end
  initial begin
    t_rom_led();
    t_eeprom();
    t_strap();
    end_sim();
  end
endmodule : boot_led_eeprom_select_bench
`default_nettype wire
